// File: include/timer16_pkg.sv
// constants and types shared by the 16-bit timer channel
package timer16_pkg;

  // register byte offsets on the register bus
  localparam logic [4:0] OFS_COUNT = 5'h00;
  localparam logic [4:0] OFS_CCA = 5'h04;
  localparam logic [4:0] OFS_CCB = 5'h08;
  localparam logic [4:0] OFS_MODE = 5'h0c;
  localparam logic [4:0] OFS_CCCTL = 5'h10;
  localparam logic [4:0] OFS_PRESC = 5'h14;
  localparam logic [4:0] OFS_OUTCTL = 5'h18;

  // mode_control fields
  localparam int MC_OVF_BIT = 0;
  localparam int MC_TOGGLE_BIT = 1;
  localparam int MC_RUN_LO = 2;
  localparam int MC_RUN_HI = 3;

  // capture_compare_control fields
  localparam int CC_A_CAPTURE_BIT = 0;
  localparam int CC_SRC_SEL_BIT = 1;
  localparam int CC_B_CAPTURE_BIT = 2;

  // prescaler_mode fields: valid edge of each timer input
  localparam int PM_EDGE_A_LO = 0;
  localparam int PM_EDGE_B_LO = 2;

  // output_control fields
  localparam int OC_ONESHOT_EN_BIT = 0;
  localparam int OC_TRIGGER_BIT = 1;

  // reset values and the count terminal value
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] CCR_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [2:0] CCCTL_RESET = 3'h0;
  localparam logic [3:0] PRESC_RESET = 4'h0;
  localparam logic [0:0] OUTCTL_RESET = 1'h0;

  // bus responses and the whole-halfword write strobe pattern
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] FULL_HALF = 2'h3;

  typedef enum logic [1:0] {
    RUN_STOP = 2'b00,
    RUN_FREE = 2'b01,
    RUN_CLEAR_EDGE = 2'b10,
    RUN_CLEAR_MATCH = 2'b11
  } run_mode_t;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_NONE = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_t;

endpackage

// File: rtl/input_edge.sv
// two-flop synchroniser and edge detector for one timer input pin
`timescale 1ns/1ps
`default_nettype none

module input_edge (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic pin, // asynchronous pin level
  output logic rise, // one-cycle pulse on rising edge
  output logic fall // one-cycle pulse on falling edge
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;
  logic rise_reg;
  logic fall_reg;
  logic rise_next;
  logic fall_next;

  // only sync_reg reads meta_reg
  always_comb begin
    rise_next = sync_reg & ~prev_reg;
    fall_next = ~sync_reg & prev_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
    end
  end

  assign rise = rise_reg;
  assign fall = fall_reg;

endmodule

`default_nettype wire

// File: rtl/ccr_unit.sv
// one 16-bit capture/compare register with write and capture ports
`timescale 1ns/1ps
`default_nettype none

module ccr_unit (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic wr_en, // software writes a whole 16-bit value
  input wire logic [15:0] wr_data, // value written by software
  input wire logic cap_en, // capture trigger, one cycle
  input wire logic [15:0] count, // live timer count
  output logic [15:0] value // held register value
);

  logic [15:0] value_reg;
  logic [15:0] value_next;

  // capture beats a same-cycle write so a measured edge is never lost
  always_comb begin
    value_next = value_reg;
    if (cap_en) begin
      value_next = count;
    end else if (wr_en) begin
      value_next = wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_reg <= timer16_pkg::CCR_RESET;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule

`default_nettype wire

// File: rtl/timer16_capture_compare_core.sv
// 16-bit timer channel with two capture/compare registers, AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none

// Operation
// - timer count is a read-only 16-bit up-counter, one step per count tick.
// - count reads live value when running, 0000H when run mode is 00.
// - count forced to 0000H on reset and when run mode is cleared.
// - edge-clear mode: valid edge on input a clears count, counting goes on.
// - match-clear mode: count clears when it equals register a.
// - one-shot mode: trigger write or input a edge clears the count.
// - both capture/compare registers are whole 16-bit, reset to 0000H.
// - compare use: register a equal to count raises match irq a.
// - register a captures on opposite input a edge or input b edge.
// - compare use: register b equal to count raises match irq b.
// - register b captures on valid edge of input a, polarity programmable.
// - captured value stays until the next capture, reset or rewrite.
// - zero compare skips match after start; matches on 0000H to 0001H.
// - opposite-edge capture gives no irq a; input b edge raises it instead.
// - register b capture ignores the capture source select bit.
// - run mode 00 stop, 01 free, 10 edge clear, 11 match clear.
module timer16_capture_compare_core (
  input wire logic aclk, // 125 MHz system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [4:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [4:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic timer_input_a, // timer input pin a, asynchronous
  input wire logic timer_input_b, // timer input pin b, asynchronous
  output logic match_irq_a, // match/capture event a, one-cycle pulse
  output logic match_irq_b // match/capture event b, one-cycle pulse
);

  // bus state
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic aw_full_reg, aw_full_next;
  logic w_full_reg, w_full_next;
  logic [4:0] waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  // timer state
  logic [3:0] mode_reg, mode_next;
  logic [2:0] ccctl_reg, ccctl_next;
  logic [3:0] presc_reg, presc_next;
  logic [0:0] outctl_reg, outctl_next;
  logic [15:0] count_reg, count_next;
  logic fresh_reg, fresh_next;
  logic irq_a_reg, irq_a_next;
  logic irq_b_reg, irq_b_next;

  // combinational helpers
  logic wr_fire;
  logic wr_whole;
  logic [4:0] wr_word;
  logic [4:0] rd_word;
  logic wr_cca, wr_ccb;
  logic one_shot_hit;
  logic running, run_next_on;
  logic valid_a, opp_a, valid_b;
  logic cap_a, cap_b;
  logic cca_capture, ccb_capture, src_opp;
  timer16_pkg::run_mode_t run_mode, run_mode_new;

  logic a_rise, a_fall, b_rise, b_fall;
  logic [15:0] cca_value, ccb_value;

  input_edge edge_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(timer_input_a),
    .rise(a_rise),
    .fall(a_fall)
  );

  input_edge edge_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(timer_input_b),
    .rise(b_rise),
    .fall(b_fall)
  );

  ccr_unit cca_unit (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_cca),
    .wr_data(wdata_reg[15:0]),
    .cap_en(cap_a),
    .count(count_reg),
    .value(cca_value)
  );

  ccr_unit ccb_unit (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_ccb),
    .wr_data(wdata_reg[15:0]),
    .cap_en(cap_b),
    .count(count_reg),
    .value(ccb_value)
  );

  // swapping rise and fall gives the opposite-phase edge
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic rise_in,
                                    input logic fall_in);
    logic hit;
    hit = 1'b0;
    unique case (timer16_pkg::edge_sel_t'(sel))
      timer16_pkg::EDGE_FALL: hit = fall_in;
      timer16_pkg::EDGE_RISE: hit = rise_in;
      timer16_pkg::EDGE_NONE: hit = 1'b0;
      timer16_pkg::EDGE_BOTH: hit = rise_in | fall_in;
    endcase
    return hit;
  endfunction

  // register bus: write and read channels
  always_comb begin
    wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
    wr_whole = (wstrb_reg[1:0] == timer16_pkg::FULL_HALF);
    wr_word = {waddr_reg[4:2], 2'b00};
    rd_word = {araddr[4:2], 2'b00};
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    if (awvalid && awready_reg) begin
      waddr_next = awaddr;
    end
    if (wvalid && wready_reg) begin
      wdata_next = wdata;
      wstrb_next = wstrb;
    end
    aw_full_next = aw_full_reg ? ~wr_fire : (awvalid & awready_reg);
    w_full_next = w_full_reg ? ~wr_fire : (wvalid & wready_reg);
    awready_next = ~aw_full_next;
    wready_next = ~w_full_next;
    bvalid_next = wr_fire | (bvalid_reg & ~bready);
    bresp_next = bresp_reg;
    if (wr_fire) begin
      bresp_next = (wr_word <= timer16_pkg::OFS_OUTCTL) ?
                   timer16_pkg::RESP_OKAY : timer16_pkg::RESP_SLVERR;
    end
    rvalid_next = (arvalid & arready_reg) | (rvalid_reg & ~rready);
    arready_next = ~rvalid_next;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (arvalid && arready_reg) begin
      rresp_next = timer16_pkg::RESP_OKAY;
      rdata_next = 32'h0000_0000;
      unique case (rd_word)
        timer16_pkg::OFS_COUNT:
          rdata_next[15:0] = running ? count_reg : 16'h0000;
        timer16_pkg::OFS_CCA: rdata_next[15:0] = cca_value;
        timer16_pkg::OFS_CCB: rdata_next[15:0] = ccb_value;
        timer16_pkg::OFS_MODE: rdata_next[3:0] = mode_reg;
        timer16_pkg::OFS_CCCTL: rdata_next[2:0] = ccctl_reg;
        timer16_pkg::OFS_PRESC: rdata_next[3:0] = presc_reg;
        timer16_pkg::OFS_OUTCTL: rdata_next[0:0] = outctl_reg;
        default: rresp_next = timer16_pkg::RESP_SLVERR;
      endcase
    end
  end

  // timer: configuration, counter, captures and match events
  always_comb begin
    run_mode = timer16_pkg::run_mode_t'(
      mode_reg[timer16_pkg::MC_RUN_HI:timer16_pkg::MC_RUN_LO]);
    running = (run_mode != timer16_pkg::RUN_STOP);
    cca_capture = ccctl_reg[timer16_pkg::CC_A_CAPTURE_BIT];
    ccb_capture = ccctl_reg[timer16_pkg::CC_B_CAPTURE_BIT];
    src_opp = ccctl_reg[timer16_pkg::CC_SRC_SEL_BIT];
    valid_a = edge_hit(presc_reg[timer16_pkg::PM_EDGE_A_LO +: 2],
                       a_rise, a_fall);
    opp_a = edge_hit(presc_reg[timer16_pkg::PM_EDGE_A_LO +: 2],
                     a_fall, a_rise);
    valid_b = edge_hit(presc_reg[timer16_pkg::PM_EDGE_B_LO +: 2],
                       b_rise, b_fall);

    // the 16-bit registers take only whole-halfword writes
    wr_cca = wr_fire & wr_whole & (wr_word == timer16_pkg::OFS_CCA);
    wr_ccb = wr_fire & wr_whole & (wr_word == timer16_pkg::OFS_CCB);

    mode_next = mode_reg;
    ccctl_next = ccctl_reg;
    presc_next = presc_reg;
    outctl_next = outctl_reg;
    one_shot_hit = 1'b0;
    if (wr_fire && wstrb_reg[0]) begin
      unique case (wr_word)
        timer16_pkg::OFS_MODE: mode_next = wdata_reg[3:0];
        timer16_pkg::OFS_CCCTL: ccctl_next = wdata_reg[2:0];
        timer16_pkg::OFS_PRESC: presc_next = wdata_reg[3:0];
        timer16_pkg::OFS_OUTCTL: begin
          outctl_next = wdata_reg[timer16_pkg::OC_ONESHOT_EN_BIT +: 1];
          // trigger bit is write-only, acts with the enable being written
          one_shot_hit = wdata_reg[timer16_pkg::OC_TRIGGER_BIT] &
                         wdata_reg[timer16_pkg::OC_ONESHOT_EN_BIT];
        end
        default: ;
      endcase
    end
    run_mode_new = timer16_pkg::run_mode_t'(
      mode_next[timer16_pkg::MC_RUN_HI:timer16_pkg::MC_RUN_LO]);
    run_next_on = (run_mode_new != timer16_pkg::RUN_STOP);

    // counter steps every cycle while running
    count_next = count_reg + 16'h0001;
    if (running && count_reg == timer16_pkg::COUNT_MAX) begin
      mode_next[timer16_pkg::MC_OVF_BIT] = 1'b1;
    end
    if (run_mode == timer16_pkg::RUN_CLEAR_EDGE && valid_a) begin
      count_next = timer16_pkg::COUNT_RESET;
    end
    if (run_mode == timer16_pkg::RUN_CLEAR_MATCH &&
        count_reg == cca_value) begin
      count_next = timer16_pkg::COUNT_RESET;
    end
    if (running && outctl_reg[0] && (one_shot_hit || valid_a)) begin
      count_next = timer16_pkg::COUNT_RESET;
    end
    if (!running || !run_next_on) begin
      count_next = timer16_pkg::COUNT_RESET;
    end

    // first cycle after a start sees count 0000H without a match
    fresh_next = ~running & run_next_on;

    // captures only while running; a stop written in the same cycle still lets the capture through
    cap_a = running & cca_capture & (src_opp ? opp_a : valid_b);
    cap_b = running & ccb_capture & valid_a;

    if (cca_capture) begin
      // input b edge raises irq a; opposite-edge capture raises nothing
      irq_a_next = running & valid_b;
    end else begin
      irq_a_next = running & ~fresh_reg & (count_reg == cca_value);
    end
    if (ccb_capture) begin
      irq_b_next = cap_b;
    end else begin
      irq_b_next = running & ~fresh_reg & (count_reg == ccb_value);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      waddr_reg <= 5'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= timer16_pkg::RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= timer16_pkg::RESP_OKAY;
      mode_reg <= timer16_pkg::MODE_RESET;
      ccctl_reg <= timer16_pkg::CCCTL_RESET;
      presc_reg <= timer16_pkg::PRESC_RESET;
      outctl_reg <= timer16_pkg::OUTCTL_RESET;
      count_reg <= timer16_pkg::COUNT_RESET;
      fresh_reg <= 1'b0;
      irq_a_reg <= 1'b0;
      irq_b_reg <= 1'b0;
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      mode_reg <= mode_next;
      ccctl_reg <= ccctl_next;
      presc_reg <= presc_next;
      outctl_reg <= outctl_next;
      count_reg <= count_next;
      fresh_reg <= fresh_next;
      irq_a_reg <= irq_a_next;
      irq_b_reg <= irq_b_next;
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign match_irq_a = irq_a_reg;
  assign match_irq_b = irq_b_reg;

endmodule

`default_nettype wire

// File: test/timer16_properties.sv
// concurrent checks on the timer channel ports
`timescale 1ns/1ps
`default_nettype none

module timer16_properties (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic awvalid, // aw valid
  input wire logic awready, // aw ready
  input wire logic wvalid, // w valid
  input wire logic wready, // w ready
  input wire logic [1:0] bresp, // b resp
  input wire logic bvalid, // b valid
  input wire logic bready, // b ready
  input wire logic [4:0] araddr, // ar addr
  input wire logic arvalid, // ar valid
  input wire logic arready, // ar ready
  input wire logic [31:0] rdata, // r data
  input wire logic [1:0] rresp, // r resp
  input wire logic rvalid, // r valid
  input wire logic rready, // r ready
  input wire logic match_irq_a, // irq a
  input wire logic match_irq_b // irq b
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence wr_answer;
    !bvalid ##1 bvalid;
  endsequence
  sequence rd_take;
    arvalid && arready;
  endsequence

  wr_latency_a: assert property (wr_take |=> wr_answer)
    else $error("write response not two cycles after handshake");
  rd_latency_a: assert property (rd_take |=> rvalid)
    else $error("read data not one cycle after handshake");
  b_stands_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before bready");
  r_stands_a: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped before rready");
  ar_blocked_a: assert property (rvalid |-> !arready)
    else $error("read address taken while data pending");
  aw_blocked_a: assert property (wr_take |=> !awready && !wready)
    else $error("write channels not blocked after handshake");
  bad_read_a: assert property ((rd_take and araddr[4:2] == 3'h7) |=>
    rresp == timer16_pkg::RESP_SLVERR && rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  good_read_a: assert property ((rd_take and araddr[4:2] != 3'h7) |=>
    rresp == timer16_pkg::RESP_OKAY && rdata[31:16] == 16'h0000)
    else $error("mapped read bad response or upper bits");
  irq_a_pulse_a: assert property (match_irq_a |=> !match_irq_a)
    else $error("irq a longer than one cycle");
  irq_b_pulse_a: assert property (match_irq_b |=> !match_irq_b)
    else $error("irq b longer than one cycle");
endmodule

bind timer16_capture_compare_core timer16_properties u_props (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .match_irq_a(match_irq_a), .match_irq_b(match_irq_b)
);
`default_nettype wire

// File: test/pin_source.sv
// model of the external signals at the two timer input pins
`timescale 1ns/1ps
`default_nettype none

module pin_source (
  input wire logic aclk, // clock
  output logic timer_input_a, // pin a
  output logic timer_input_b // pin b
);
  initial begin
    timer_input_a = 1'b0;
    timer_input_b = 1'b0;
  end

  // ten cycles each level, well past the two-flop synchroniser
  task automatic pulse(input logic sel);
    if (sel) timer_input_b <= 1'b1;
    else timer_input_a <= 1'b1;
    repeat (10) @(posedge aclk);
    if (sel) timer_input_b <= 1'b0;
    else timer_input_a <= 1'b0;
    repeat (10) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// File: test/test_timer16_capture_compare_core.sv
// self-checking bench for the 16-bit timer channel
`timescale 1ns/1ps
`default_nettype none

module test_timer16_capture_compare_core;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq_a, irq_b, pin_a, pin_b;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] v1, v2;
  int miscompares = 0, n_compared = 0, na = 0, nb = 0, a0, b0;

  timer16_capture_compare_core dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .timer_input_a(pin_a), .timer_input_b(pin_b),
    .match_irq_a(irq_a), .match_irq_b(irq_b));
  pin_source pins (.aclk(aclk), .timer_input_a(pin_a), .timer_input_b(pin_b));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (irq_a === 1'b1) na++;
    if (irq_b === 1'b1) nb++;
  end

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk(input logic c);
    check_word({31'h0, c}, 32'h0000_0001);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awready === 1'b1 && !ad) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (wready === 1'b1 && !wd) begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check_resp(bresp, er);
  endtask

  task automatic w(input logic [4:0] a, input logic [31:0] d);
    wr(a, d, 4'hf, timer16_pkg::RESP_OKAY);
  endtask

  task automatic rd_raw(input logic [4:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    rd_raw(a);
    check_resp(rs, timer16_pkg::RESP_OKAY);
    check_word(rd, exp);
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // full run is about 67k cycles, dominated by the wrap
  initial begin
    #700000;
    miscompares++;
    summarize();
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    cyc(20);
    aresetn <= 1'b1;
    cyc(2);
    rdchk(timer16_pkg::OFS_COUNT, 32'h0000_0000);
    rdchk(timer16_pkg::OFS_CCA, 32'h0000_0000);
    rdchk(timer16_pkg::OFS_CCB, 32'h0000_0000);
    w(timer16_pkg::OFS_CCA, 32'habcd_1234);
    rdchk(timer16_pkg::OFS_CCA, 32'h0000_1234);
    wr(timer16_pkg::OFS_CCA, 32'h0000_5678, 4'h1, timer16_pkg::RESP_OKAY);
    rdchk(timer16_pkg::OFS_CCA, 32'h0000_1234);
    wr(5'h1c, 32'h0000_0001, 4'hf, timer16_pkg::RESP_SLVERR);
    rd_raw(5'h1c);
    check_resp(rs, timer16_pkg::RESP_SLVERR);
    check_word(rd, 32'h0000_0000);
    w(timer16_pkg::OFS_COUNT, 32'h0000_0055);
    rdchk(timer16_pkg::OFS_COUNT, 32'h0000_0000);
    // compare values only ever change while stopped
    w(timer16_pkg::OFS_CCA, 32'h0000_0040);
    w(timer16_pkg::OFS_CCB, 32'h0000_0000);
    a0 = na;
    b0 = nb;
    w(timer16_pkg::OFS_MODE, 32'h0000_0004);
    cyc(100);
    check_word(32'(na - a0), 32'h0000_0001);
    check_word(32'(nb - b0), 32'h0000_0000);
    rd_raw(timer16_pkg::OFS_COUNT);
    chk(rd > 32'h0000_0060);
    w(timer16_pkg::OFS_MODE, 32'h0000_0000);
    rdchk(timer16_pkg::OFS_COUNT, 32'h0000_0000);
    w(timer16_pkg::OFS_CCA, 32'h0000_0010);
    w(timer16_pkg::OFS_CCB, 32'h0000_0008);
    a0 = na;
    b0 = nb;
    w(timer16_pkg::OFS_MODE, 32'h0000_000c);
    for (int i = 0; i < 6; i++) begin
      rd_raw(timer16_pkg::OFS_COUNT);
      chk(rd <= 32'h0000_0010);
    end
    cyc(40);
    chk(na - a0 >= 3);
    chk(nb - b0 >= 3);
    w(timer16_pkg::OFS_MODE, 32'h0000_0000);
    w(timer16_pkg::OFS_PRESC, 32'h0000_0001);
    w(timer16_pkg::OFS_CCA, 32'h0000_ffff);
    w(timer16_pkg::OFS_MODE, 32'h0000_0008);
    cyc(150);
    pins.pulse(1'b0);
    rd_raw(timer16_pkg::OFS_COUNT);
    chk(rd < 32'h0000_0020);
    w(timer16_pkg::OFS_MODE, 32'h0000_0000);
    w(timer16_pkg::OFS_CCCTL, 32'h0000_0005);
    w(timer16_pkg::OFS_PRESC, 32'h0000_0005);
    a0 = na;
    b0 = nb;
    w(timer16_pkg::OFS_MODE, 32'h0000_0004);
    cyc(40);
    pins.pulse(1'b0);
    pins.pulse(1'b1);
    rd_raw(timer16_pkg::OFS_CCB);
    v1 = rd[15:0];
    rd_raw(timer16_pkg::OFS_CCA);
    v2 = rd[15:0];
    chk(v1 > 16'h0020);
    check_word({16'h0, v2 - v1}, 32'h0000_0014);
    chk(na - a0 == 1 && nb - b0 == 1);
    cyc(30);
    rdchk(timer16_pkg::OFS_CCB, {16'h0, v1});
    w(timer16_pkg::OFS_MODE, 32'h0000_0000);
    w(timer16_pkg::OFS_CCCTL, 32'h0000_0007);
    // input b on both edges, input a still rising
    w(timer16_pkg::OFS_PRESC, 32'h0000_000d);
    a0 = na;
    b0 = nb;
    w(timer16_pkg::OFS_MODE, 32'h0000_0004);
    cyc(100);
    pins.pulse(1'b0);
    rd_raw(timer16_pkg::OFS_CCB);
    v1 = rd[15:0];
    rd_raw(timer16_pkg::OFS_CCA);
    v2 = rd[15:0];
    chk(v1 > 16'h0050);
    check_word({16'h0, v2 - v1}, 32'h0000_000a);
    chk(na == a0 && nb - b0 == 1);
    pins.pulse(1'b1);
    chk(na - a0 == 2);
    rdchk(timer16_pkg::OFS_CCA, {16'h0, v2});
    // input b set to no valid edge: no further event
    w(timer16_pkg::OFS_PRESC, 32'h0000_0009);
    pins.pulse(1'b1);
    chk(na - a0 == 2);
    w(timer16_pkg::OFS_MODE, 32'h0000_0000);
    w(timer16_pkg::OFS_CCCTL, 32'h0000_0000);
    w(timer16_pkg::OFS_OUTCTL, 32'h0000_0001);
    w(timer16_pkg::OFS_MODE, 32'h0000_0004);
    cyc(200);
    w(timer16_pkg::OFS_OUTCTL, 32'h0000_0003);
    rd_raw(timer16_pkg::OFS_COUNT);
    chk(rd < 32'h0000_0010);
    // falling edge of input a is the valid one now; a rise clear reads high
    w(timer16_pkg::OFS_PRESC, 32'h0000_0008);
    cyc(100);
    pins.pulse(1'b0);
    rd_raw(timer16_pkg::OFS_COUNT);
    chk(rd < 32'h0000_0010);
    w(timer16_pkg::OFS_MODE, 32'h0000_0000);
    w(timer16_pkg::OFS_OUTCTL, 32'h0000_0000);
    w(timer16_pkg::OFS_MODE, 32'h0000_0004);
    cyc(65536);
    rdchk(timer16_pkg::OFS_MODE, 32'h0000_0005);
    rd_raw(timer16_pkg::OFS_COUNT);
    chk(rd < 32'h0000_0020);
    w(timer16_pkg::OFS_MODE, 32'h0000_0000);
    rdchk(timer16_pkg::OFS_COUNT, 32'h0000_0000);
    summarize();
  end
endmodule
`default_nettype wire
